//--- sdcs_dap.sv
// Purpose: Stand-in for the audio processor
// Assumes: Left word first, MSB at the frame edge
// Notes: Samples on bit clock rise, away from the shift edge
`timescale 1ns/100ps
module sdcs_dap (
  input wire logic frame_clk,
  input wire logic bit_clk,
  input wire logic sdata,
  output logic [23:0] left_word,
  output int frames
);
  logic [23:0] sh = 24'h00_0000; // Left half bits
  int k = 0; // Bits taken so far
  initial frames = 0;
  // First 24 bits of the high half
  always @(posedge bit_clk) begin
    if (frame_clk && k < 24) begin
      sh = {sh[22:0], sdata};
      k++;
    end
    if (!frame_clk) k = 0;
  end
  // Word out as the right half starts
  always @(negedge frame_clk) begin
    left_word = sh;
    frames++;
  end
endmodule : sdcs_dap

//--- sdcs_decim.sv
// Purpose: Boxcar decimator from one-bit streams to 24-bit words
// Assumes: tick per modulator bit, dump on a frame's last cycle
// Notes: Positive full scale clips one code short of wrap
`timescale 1ns/100ps
module sdcs_decim (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic dump,
  input wire logic [2:0] osr_log,
  input wire logic bit_l,
  input wire logic bit_r,
  output logic [sdcs_pkg::WORD_W-1:0] word_l,
  output logic [sdcs_pkg::WORD_W-1:0] word_r,
  output logic word_valid
);
  // Bits by channel, left first
  logic [1:0] bits;
  // Shift from sum to word full scale
  logic [4:0] scale;
  logic [sdcs_pkg::WORD_W-1:0] word_q [2];
  logic valid_q;

  assign bits = {bit_r, bit_l};
  assign scale = sdcs_pkg::WORD_MSB - {2'b00, osr_log};
  assign word_l = word_q[0];
  assign word_r = word_q[1];
  assign word_valid = valid_q;

  // One integrate-and-dump per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [sdcs_pkg::ACC_W-1:0] acc_q;
    logic signed [sdcs_pkg::ACC_W-1:0] acc_d;
    logic signed [31:0] wide;
    // Sum includes the dump-cycle bit
    always_comb begin
      acc_d = acc_q;
      if (tick) begin
        acc_d = bits[ch] ? acc_q + 9'sd1 : acc_q - 9'sd1;
      end
      wide = 32'(acc_d) <<< scale;
    end
    // Accumulate per tick, clipped word per frame
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        acc_q <= '0;
        word_q[ch] <= sdcs_pkg::WORD_RST;
      end else if (clk_en) begin
        if (dump) begin
          acc_q <= '0; // R6
          if (wide > 32'sh007F_FFFF) begin
            word_q[ch] <= 24'h7F_FFFF;
          end else if (wide < -32'sh0080_0000) begin
            word_q[ch] <= 24'h80_0000;
          end else begin
            word_q[ch] <= wide[sdcs_pkg::WORD_W-1:0]; // R6
          end
        end else begin
          acc_q <= acc_d;
        end
      end
    end
  end

  // Word strobe, a cycle after dump
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
    end else if (clk_en) begin
      valid_q <= dump;
    end
  end
endmodule : sdcs_decim

//--- sdcs_hpf.sv
// Purpose: Shared DC-removing high-pass stage, left then right
// Assumes: in_valid at most once per sample period
// Notes: Leaky differentiator; skip passes words through
`timescale 1ns/100ps
module sdcs_hpf (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic skip,
  input wire logic [sdcs_pkg::WORD_W-1:0] in_l,
  input wire logic [sdcs_pkg::WORD_W-1:0] in_r,
  output logic [sdcs_pkg::WORD_W-1:0] out_l,
  output logic [sdcs_pkg::WORD_W-1:0] out_r
);
  localparam int HPF_W = sdcs_pkg::HPF_W;
  typedef enum logic [1:0] {HP_IDLE, HP_LEFT, HP_RIGHT} sdcs_hp_state_t;
  sdcs_hp_state_t state_q;
  // Per-channel history
  logic signed [sdcs_pkg::HPF_W-1:0] xin_q [2];
  logic signed [sdcs_pkg::HPF_W-1:0] xprev_q [2];
  logic signed [sdcs_pkg::HPF_W-1:0] yprev_q [2];
  logic [sdcs_pkg::WORD_W-1:0] out_q [2];
  logic ch;
  logic signed [sdcs_pkg::HPF_W-1:0] y;
  logic signed [sdcs_pkg::HPF_W-1:0] ysat;

  assign ch = (state_q == HP_RIGHT);
  assign out_l = out_q[0];
  assign out_r = out_q[1];

  // Leaky difference, clipped to word range
  always_comb begin
    y = xin_q[ch] - xprev_q[ch] + yprev_q[ch] - (yprev_q[ch] >>> sdcs_pkg::HPF_SHIFT);
    ysat = y;
    if (y > 26'sh07F_FFFF) begin
      ysat = 26'sh07F_FFFF;
    end else if (y < -26'sh080_0000) begin
      ysat = -26'sh080_0000;
    end
  end

  // Sequencer: left, then right
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= HP_IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        HP_IDLE: state_q <= in_valid ? HP_LEFT : HP_IDLE;
        HP_LEFT: state_q <= HP_RIGHT; // R9
        HP_RIGHT: state_q <= HP_IDLE;
      endcase
    end
  end

  // Input capture and filter update
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      xin_q <= '{default: '0};
      xprev_q <= '{default: '0};
      yprev_q <= '{default: '0};
      out_q <= '{default: '0};
    end else if (clk_en) begin
      if (state_q == HP_IDLE && in_valid) begin
        xin_q[0] <= HPF_W'($signed(in_l));
        xin_q[1] <= HPF_W'($signed(in_r));
      end else if (state_q != HP_IDLE) begin
        xprev_q[ch] <= xin_q[ch];
        if (skip) begin
          // Cleared so re-enabling starts clean
          yprev_q[ch] <= '0;
          out_q[ch] <= xin_q[ch][sdcs_pkg::WORD_W-1:0]; // R10
        end else begin
          yprev_q[ch] <= ysat;
          out_q[ch] <= ysat[sdcs_pkg::WORD_W-1:0]; // R7
        end
      end
    end
  end
endmodule : sdcs_hpf

//--- sdcs_monitor.sv
// Purpose: Port-level checker for the decimation back end
// Assumes: Master mode; ratio taken from the select pins
// Notes: A counter measures frame halves, too long for repetition
`timescale 1ns/100ps
module sdcs_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic master_clock_in,
  input wire logic [2:0] ratio_sel,
  input wire logic slave_mode,
  input wire logic onebit_stream_mode,
  input wire logic frame_clk_out,
  input wire logic bit_clk_oe_n,
  input wire logic serial_data_out,
  input wire logic onebit_left_out
);
  // Half-frame length in master clocks per select code
  localparam logic [9:0] HALF [8] = '{10'h180, 10'h100, 10'h0c0, 10'h080,
    10'h0c0, 10'h080, 10'h060, 10'h040};
  logic [9:0] run_q; // Run length
  logic lvl_q; // Last frame level
  logic seen_q; // A fall passed, so runs are whole
  wire edge_w = frame_clk_out != lvl_q;
  // Level run lengths; the first high half after reset is one short
  always_ff @(posedge master_clock_in or posedge reset) begin
    if (reset) begin
      run_q <= 10'h000;
      lvl_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      run_q <= edge_w ? 10'h001 : run_q + 10'h001;
      lvl_q <= frame_clk_out;
      seen_q <= seen_q | (edge_w & lvl_q);
    end
  end
  sequence s_aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  a_aw_refused: assert property (@(posedge clock) disable iff (reset)
    s_aw_take |=> !s_axi_awready) else $error("awready after take");
  a_write_answer: assert property (@(posedge clock) disable iff (reset)
    s_aw_take |-> ##[1:3] s_axi_bvalid) else $error("no write answer");
  a_b_stands: assert property (@(posedge clock) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_read_answer: assert property (@(posedge clock) disable iff (reset)
    s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid) else $error("no read answer");
  a_frame_half: assert property (@(posedge master_clock_in) disable iff (reset)
    seen_q && edge_w && !slave_mode && !onebit_stream_mode |-> run_q == HALF[ratio_sel])
    else $error("frame half length");
  a_master_drives: assert property (@(posedge master_clock_in) disable iff (reset)
    seen_q && !slave_mode && !onebit_stream_mode |-> !bit_clk_oe_n) else $error("bit clock off");
  a_onebit_idle: assert property (@(posedge master_clock_in) disable iff (reset)
    !onebit_stream_mode |-> !onebit_left_out) else $error("stream pin active");
  a_serial_quiet: assert property (@(posedge master_clock_in) disable iff (reset)
    onebit_stream_mode |-> !serial_data_out) else $error("serial data in stream mode");
endmodule : sdcs_monitor
bind sdcs_top sdcs_monitor mon (.*);

//--- sdcs_pkg.sv
// Purpose: Shared constants and types of the back end
// Assumes: 32-bit AXI4-Lite registers, link on the master clock
// Notes: Offsets, reset values and counts shared by the design and the bench
package sdcs_pkg;
  // Register byte offsets
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STATUS_OFF = 4'h4;
  localparam logic [3:0] LEFT_OFF = 4'h8;
  localparam logic [3:0] RIGHT_OFF = 4'hC;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sample path widths
  localparam int WORD_W = 24;
  localparam int ACC_W = 9;
  localparam int HPF_W = 26;
  localparam int HPF_SHIFT = 10;
  localparam logic [4:0] WORD_MSB = 5'h17;
  localparam logic [23:0] WORD_RST = 24'h00_0000;
  // Master-clock-per-sample ratios
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_192 = 10'h0C0;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_768 = 10'h300;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  // Log2 of bit slots per sample
  localparam int BCK_LOG = 6;
  // Log2 oversampling per rate
  localparam logic [2:0] OSR_LOG_SINGLE = 3'h7;
  localparam logic [2:0] OSR_LOG_DUAL = 3'h6;
  localparam logic [2:0] OSR_LOG_QUAD = 3'h5;
  // Modulator rate classes
  typedef enum logic [1:0] {RATE_SINGLE, RATE_DUAL, RATE_QUAD} sdcs_rate_t;
endpackage : sdcs_pkg

//--- sdcs_top.sv
// Purpose: Stereo decimation back end, ratio select, DC removal, serial out
// Assumes: Modulator bits on the master clock; pins change only in reset
// Notes: Link logic runs on master_clock_in, registers on clock, crossing by handshake
// Notes on behaviour
// [R1] Ratios 128/256/384/512/768; 192 master quad only
// [R2] Master mode: ratio comes from select pins
// [R3] Slave mode: ratio measured against frame clock
// [R4] Far side fixes pins for one-bit mode
// [R5] Modulator rate 128, 64 or 32 per sample
// [R6] Decimate to one 24-bit word per sample
// [R7] High-pass then serialize left/right, master or slave
// [R8] One-bit mode sends modulator bits to pins
// [R9] Two modulators share decimator, filter and serializer
// [R10] Skip pin high disables the high-pass stage
// [R11] Far side holds reset while changing pins
// [R12] Sample path clocked from master clock pin
`timescale 1ns/100ps
module sdcs_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sdcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [sdcs_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic master_clock_in,
  input wire logic [2:0] ratio_sel,
  input wire logic slave_mode,
  input wire logic onebit_stream_mode,
  input wire logic hpf_skip,
  input wire logic mod_left_bit,
  input wire logic mod_right_bit,
  input wire logic frame_clk_in,
  output logic frame_clk_out,
  output logic frame_clk_oe_n,
  input wire logic bit_clk_in,
  output logic bit_clk_out,
  output logic bit_clk_oe_n,
  output logic serial_data_out,
  output logic onebit_left_out,
  output logic onebit_right_out
);
  // ---- Link domain (master_clock_in) ----
  logic [1:0] lrst_q; // Reset synchroniser, async assert
  logic lrst;
  logic [11:0] sync_raw;
  logic [11:0] sync1_q; // First stage, read only by sync2_q
  logic [11:0] sync2_q;
  logic [1:0] edge_q; // Last frame and bit clock levels
  logic ack_b_q; // Bus-side acknowledge toggle
  logic [1:0] ctrl_q; // Software control bits
  logic lce, slave, obm, skip_l, mute_l, frame_s, bit_s, ack_l;
  logic [2:0] sel;
  logic frame_rise, frame_fall, bit_fall;
  logic [9:0] m_n, n_use, tick_div, bdiv, fcnt_q, fcnt_d, tcnt_q, tcnt_d, bcnt_q, bcnt_d;
  logic [9:0] meas_q, det_n_q;
  logic det_ok_q, ratio_ok, m_legal;
  sdcs_pkg::sdcs_rate_t m_rate, s_rate, rate;
  logic [2:0] osr_log;
  logic frame_start, half_start, tick, shift_ev;
  logic [sdcs_pkg::WORD_W-1:0] dec_l, dec_r, hp_l, hp_r, sh_q, sh_d;
  logic dec_valid;
  logic frame_q, frame_oe_n_q, bit_q, bit_oe_n_q, data_q, ob_l_q, ob_r_q;
  logic req_q; // Snapshot request toggle
  logic [15:0] hold_status;
  logic [sdcs_pkg::WORD_W-1:0] hold_l, hold_r;
  logic [15:0] status_word;

  assign lrst = lrst_q[1];
  assign sync_raw = {ack_b_q, ctrl_q, clk_en, frame_clk_in, bit_clk_in, hpf_skip,
                     onebit_stream_mode, slave_mode, ratio_sel};
  assign sel = sync2_q[2:0];
  assign slave = sync2_q[3];
  assign obm = sync2_q[4] & ~sync2_q[3]; // One-bit only in master
  assign bit_s = sync2_q[6];
  assign frame_s = sync2_q[7];
  assign lce = sync2_q[8];
  assign skip_l = sync2_q[5] | sync2_q[9]; // R10
  assign mute_l = sync2_q[10];
  assign ack_l = sync2_q[11];
  assign frame_rise = frame_s & ~edge_q[1];
  assign frame_fall = ~frame_s & edge_q[1];
  assign bit_fall = ~bit_s & edge_q[0];

  // Reset release on the master clock
  always_ff @(posedge master_clock_in or posedge reset) begin
    if (reset) begin
      lrst_q <= 2'b11;
    end else begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end

  // Two-stage synchroniser for the select, mode, skip and clock pins and bus-side levels
  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
    end
  end

  // Master ratio table from the select pins
  always_comb begin
    m_legal = 1'b1;
    unique case (sel)
      3'b000: begin m_n = sdcs_pkg::RATIO_768; m_rate = sdcs_pkg::RATE_SINGLE; end
      3'b001: begin m_n = sdcs_pkg::RATIO_512; m_rate = sdcs_pkg::RATE_SINGLE; end
      3'b010: begin m_n = sdcs_pkg::RATIO_384; m_rate = sdcs_pkg::RATE_SINGLE; end
      3'b011: begin m_n = sdcs_pkg::RATIO_256; m_rate = sdcs_pkg::RATE_SINGLE; end
      3'b100: begin m_n = sdcs_pkg::RATIO_384; m_rate = sdcs_pkg::RATE_DUAL; end
      3'b101: begin m_n = sdcs_pkg::RATIO_256; m_rate = sdcs_pkg::RATE_DUAL; end
      3'b110: begin m_n = sdcs_pkg::RATIO_192; m_rate = sdcs_pkg::RATE_QUAD; end
      3'b111: begin m_n = sdcs_pkg::RATIO_128; m_rate = sdcs_pkg::RATE_QUAD; end
    endcase
    // One-bit uses only dual-rate rows
    if (obm && sel[2:1] != 2'b10) begin
      m_legal = 1'b0; // R4
    end
  end

  // Slave rate pins; upper codes are reserved
  always_comb begin
    unique case (sel)
      3'b001: s_rate = sdcs_pkg::RATE_DUAL;
      3'b010: s_rate = sdcs_pkg::RATE_QUAD;
      default: s_rate = sdcs_pkg::RATE_SINGLE;
    endcase
  end

  // Effective ratio, rate and lock
  always_comb begin
    n_use = slave ? det_n_q : m_n; // R2 R3
    rate = slave ? s_rate : m_rate;
    unique case (rate)
      sdcs_pkg::RATE_DUAL: osr_log = sdcs_pkg::OSR_LOG_DUAL; // R5
      sdcs_pkg::RATE_QUAD: osr_log = sdcs_pkg::OSR_LOG_QUAD; // R5
      default: osr_log = sdcs_pkg::OSR_LOG_SINGLE; // R5
    endcase
    // Slave quad needs 128; 192 is never detected
    ratio_ok = slave ? (det_ok_q && sel[2:0] <= 3'b010 &&
                        (rate != sdcs_pkg::RATE_QUAD || det_n_q == sdcs_pkg::RATIO_128))
                     : m_legal; // R1
    tick_div = n_use >> osr_log;
    bdiv = n_use >> sdcs_pkg::BCK_LOG;
  end

  // Slave detector: master clocks between frame rising edges
  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      meas_q <= '0;
      det_n_q <= sdcs_pkg::RATIO_256;
      det_ok_q <= 1'b0;
    end else if (lce) begin
      if (frame_rise) begin
        meas_q <= 10'h001;
        if (meas_q == sdcs_pkg::RATIO_128 || meas_q == sdcs_pkg::RATIO_256 ||
            meas_q == sdcs_pkg::RATIO_384 || meas_q == sdcs_pkg::RATIO_512 ||
            meas_q == sdcs_pkg::RATIO_768) begin
          det_n_q <= meas_q; // R3
          det_ok_q <= 1'b1;
        end else begin
          det_ok_q <= 1'b0;
        end
      end else if (meas_q != sdcs_pkg::CNT_MAX) begin
        meas_q <= meas_q + 10'h001;
      end
    end
  end

  // Frame, modulator-tick and bit-clock counters
  always_comb begin
    frame_start = slave ? frame_rise : (fcnt_q == n_use - 10'h001);
    fcnt_d = frame_start ? '0 : fcnt_q + 10'h001;
    half_start = slave ? frame_fall : (fcnt_d == (n_use >> 1));
    tick = (tcnt_q == tick_div - 10'h001);
    tcnt_d = (frame_start || tick) ? '0 : tcnt_q + 10'h001;
    bcnt_d = (frame_start || bcnt_q == bdiv - 10'h001) ? '0 : bcnt_q + 10'h001;
    shift_ev = slave ? bit_fall : (bcnt_d == '0);
  end

  // Counters on the master clock
  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      fcnt_q <= '0;
      tcnt_q <= '0;
      bcnt_q <= '0;
      edge_q <= '0;
    end else if (lce) begin
      fcnt_q <= fcnt_d; // R12
      tcnt_q <= tcnt_d;
      bcnt_q <= bcnt_d;
      edge_q <= {frame_s, bit_s};
    end
  end

  // Shared decimator for both modulator streams
  sdcs_decim u_decim (
    .clock(master_clock_in),
    .reset(lrst),
    .clk_en(lce),
    .tick(tick),
    .dump(frame_start),
    .osr_log(osr_log),
    .bit_l(mod_left_bit),
    .bit_r(mod_right_bit),
    .word_l(dec_l),
    .word_r(dec_r),
    .word_valid(dec_valid)
  );

  // Shared DC-removal stage
  sdcs_hpf u_hpf (
    .clock(master_clock_in),
    .reset(lrst),
    .clk_en(lce),
    .in_valid(dec_valid),
    .skip(skip_l),
    .in_l(dec_l),
    .in_r(dec_r),
    .out_l(hp_l),
    .out_r(hp_r)
  );

  // Shifter: left at frame start, right at half frame
  always_comb begin
    sh_d = sh_q;
    if (frame_start) begin
      sh_d = (mute_l || !ratio_ok) ? '0 : hp_l; // R7
    end else if (half_start) begin
      sh_d = (mute_l || !ratio_ok) ? '0 : hp_r; // R7
    end else if (shift_ev) begin
      sh_d = {sh_q[sdcs_pkg::WORD_W-2:0], 1'b0};
    end
  end

  // Pin drivers; clocks are outputs only in master mode
  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      sh_q <= '0;
      data_q <= 1'b0;
      frame_q <= 1'b0;
      bit_q <= 1'b0;
      frame_oe_n_q <= 1'b1;
      bit_oe_n_q <= 1'b1;
    end else if (lce) begin
      sh_q <= sh_d;
      data_q <= sh_d[sdcs_pkg::WORD_W-1] & ~obm; // R7
      frame_oe_n_q <= slave;
      bit_oe_n_q <= slave | obm;
      // One-bit mode: frame pin carries the stream clock
      frame_q <= obm ? (tcnt_d < (tick_div >> 1)) : (fcnt_d < (n_use >> 1)); // R8
      bit_q <= (bcnt_d >= (bdiv >> 1));
    end
  end

  // One-bit streams straight from the modulators
  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      ob_l_q <= 1'b0;
      ob_r_q <= 1'b0;
    end else if (lce) begin
      if (!obm) begin
        ob_l_q <= 1'b0;
        ob_r_q <= 1'b0;
      end else if (tick) begin
        ob_l_q <= mod_left_bit; // R8
        ob_r_q <= mod_right_bit; // R8
      end
    end
  end

  assign status_word = {~skip_l, ratio_ok, obm, slave, rate, n_use};

  // Snapshot source, held until acknowledged
  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      req_q <= 1'b0;
      hold_status <= sdcs_pkg::STATUS_RST;
      hold_l <= '0;
      hold_r <= '0;
    end else if (lce && frame_start && req_q == ack_l) begin
      req_q <= ~req_q;
      hold_status <= status_word;
      hold_l <= hp_l;
      hold_r <= hp_r;
    end
  end

  assign frame_clk_out = frame_q;
  assign frame_clk_oe_n = frame_oe_n_q;
  assign bit_clk_out = bit_q;
  assign bit_clk_oe_n = bit_oe_n_q;
  assign serial_data_out = data_q;
  assign onebit_left_out = ob_l_q;
  assign onebit_right_out = ob_r_q;

  // ---- Register domain (clock) ----
  logic req_b1_q, req_b2_q; // Request toggle synchroniser
  logic [15:0] status_q;
  logic [sdcs_pkg::WORD_W-1:0] left_q, right_q;
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [sdcs_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q, rdata_q, rdata_d;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q, rresp_d;
  logic aw_take, w_take, wr_do, ar_take;

  assign aw_take = s_axi_awvalid & awready_q;
  assign w_take = s_axi_wvalid & wready_q;
  assign wr_do = aw_have_q & w_have_q & ~bvalid_q;
  assign ar_take = s_axi_arvalid & arready_q;

  // Snapshot sink, copied once the toggle settles
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_b1_q <= 1'b0;
      req_b2_q <= 1'b0;
      ack_b_q <= 1'b0;
      status_q <= sdcs_pkg::STATUS_RST;
      left_q <= '0;
      right_q <= '0;
    end else if (clk_en) begin
      req_b1_q <= req_q;
      req_b2_q <= req_b1_q;
      if (req_b2_q != ack_b_q) begin
        ack_b_q <= req_b2_q;
        status_q <= hold_status;
        left_q <= hold_l;
        right_q <= hold_r;
      end
    end
  end

  // AW and W in either order; response after both
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= sdcs_pkg::RESP_OKAY;
      aw_addr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        // Only the control word is writable
        bresp_q <= (aw_addr_q == sdcs_pkg::CTRL_OFF) ? sdcs_pkg::RESP_OKAY
                                                     : sdcs_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      awready_q <= ~aw_take & ~(aw_have_q & ~wr_do);
      wready_q <= ~w_take & ~(w_have_q & ~wr_do);
    end
  end

  // Control register, low byte lane only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q <= sdcs_pkg::CTRL_RST;
    end else if (clk_en && wr_do && aw_addr_q == sdcs_pkg::CTRL_OFF && wstrb_q[0]) begin
      ctrl_q <= wdata_q[1:0];
    end
  end

  // Read select; unmapped reads give zero and an error
  always_comb begin
    rdata_d = '0;
    rresp_d = sdcs_pkg::RESP_OKAY;
    unique case (s_axi_araddr)
      sdcs_pkg::CTRL_OFF: rdata_d = {30'h0, ctrl_q};
      sdcs_pkg::STATUS_OFF: rdata_d = {16'h0, status_q};
      sdcs_pkg::LEFT_OFF: rdata_d = {8'h00, left_q};
      sdcs_pkg::RIGHT_OFF: rdata_d = {8'h00, right_q};
      default: rresp_d = sdcs_pkg::RESP_SLVERR;
    endcase
  end

  // Read channel
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= sdcs_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rdata_d;
        rresp_q <= rresp_d;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      arready_q <= ~ar_take & ~(rvalid_q & ~s_axi_rready);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : sdcs_top

//--- tb_stereo_decimation_clock_select.sv
// Purpose: Self-checking bench
// Assumes: Modulator bits high, so words clip at full scale
// Notes: Pins change only under reset
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_stereo_decimation_clock_select;
  logic clock = 0, reset = 1, clk_en = 1, master_clock_in = 0, slave_mode = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, onebit_stream_mode = 0, hpf_skip = 1, mod_left_bit = 1;
  logic mod_right_bit = 1, frame_clk_in, bit_clk_in, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_clk_out, frame_clk_oe_n, bit_clk_out;
  logic bit_clk_oe_n, serial_data_out, onebit_left_out, onebit_right_out;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [2:0] ratio_sel = 3'h3;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, exp_w, seed = 32'hd07f_e1ff;
  logic [31:0] exp_q [$];
  logic [23:0] left_rx;
  int miscompares = 0, total_checks = 0, frames;
  // Released clock pins fall to the pulldown level
  assign frame_clk_in = frame_clk_oe_n ? 1'b0 : frame_clk_out;
  assign bit_clk_in = bit_clk_oe_n ? 1'b0 : bit_clk_out;
  sdcs_top dut (.*);
  sdcs_dap far (.frame_clk(frame_clk_in), .bit_clk(bit_clk_in), .sdata(serial_data_out),
    .left_word(left_rx), .frames(frames));
  always #50 clock = ~clock;
  always #15 master_clock_in = ~master_clock_in;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task stuck(input logic busy);
    if (busy) begin
      miscompares++;
      give_verdict();
    end
  endtask : stuck
  // One AXI4-Lite transfer; answer noted in queue
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    exp_q.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (int i = 0; i < 40 && (i == 0 || s_axi_bready || s_axi_rready); i++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_bvalid) s_axi_bready <= 0;
      if (s_axi_rvalid) s_axi_rready <= 0;
    end
    stuck(s_axi_bready || s_axi_rready);
  endtask : bus
  // Answer against oldest note
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
      exp_w = exp_q.pop_front();
      `CHK(s_axi_bvalid ? {30'h0, s_axi_bresp} : s_axi_rdata, exp_w)
    end
  end
  // Reset with new pins, run 8 frames, or 200 clocks in one-bit mode
  task cfg(input logic [2:0] sel, input logic ob, input logic sk);
    int f0;
    f0 = frames;
    reset <= 1;
    ratio_sel <= sel;
    onebit_stream_mode <= ob;
    hpf_skip <= sk;
    repeat (3) @(posedge clock);
    reset <= 0;
    for (int i = 0; i < 2000 && (ob ? i < 200 : frames < f0 + 8); i++) @(posedge clock);
    stuck(!ob && frames < f0 + 8);
  endtask : cfg
  initial begin
    @(posedge clock);
    cfg(3'h3, 1'b0, 1'b1);
    bus(0, sdcs_pkg::STATUS_OFF, 0, 32'h0000_4100);
    bus(0, sdcs_pkg::LEFT_OFF, 0, 32'h007f_ffff);
    bus(0, sdcs_pkg::RIGHT_OFF, 0, 32'h007f_ffff);
    `CHK(left_rx, 24'h7f_ffff)
    seed = xs(seed);
    bus(1, sdcs_pkg::CTRL_OFF, seed & 32'hffff_fffc, {30'h0, sdcs_pkg::RESP_OKAY});
    bus(0, sdcs_pkg::CTRL_OFF, 0, 32'h0000_0000);
    bus(1, sdcs_pkg::STATUS_OFF, xs(seed), {30'h0, sdcs_pkg::RESP_SLVERR});
    cfg(3'h7, 1'b0, 1'b0);
    bus(0, sdcs_pkg::STATUS_OFF, 0, 32'h0000_c880);
    cfg(3'h5, 1'b1, 1'b1);
    `CHK({onebit_left_out, onebit_right_out, serial_data_out}, 3'b110)
    give_verdict();
  end
endmodule : tb_stereo_decimation_clock_select
